/* disp_defines.svh */
// Functional notes
// - Cursor control and compression latch at vblank, pipe off or cursor off, after base write.
// - Plane control latches with surface base write at vblank, pipe off or plane off.
// - 8888 blue-first: alpha 31:24, red 23:16, green 15:8, blue 7:0.
// - 8888 red-first: alpha 31:24, red 7:0, green 15:8, blue 23:16.
// - 2:10:10:10: alpha 31:30, green 19:10; red/blue 29:20 and 9:0 by order.
// - Half-float: alpha 63:48, green 31:16; red/blue 47:32 and 15:0 by order.
// - 64-bit unsigned: colour lanes as half-float, alpha from 63:56 only.
// - Half-float and 64-bit unsigned formats accepted only on planes one to three.
// - Higher precision from planes 1-3, SDR planes bypassed, only in pipe HDR mode.
// - 8-bit 4:2:0: luma 7:0; chroma word U 15:8, V 7:0.
// - 10/12/16-bit 4:2:0: MSB-aligned luma and V low lane, U high lane.
// - 8-bit 4:2:2: four byte orders in each 32-bit word.
// - Deep 4:2:2: four MSB-aligned 16-bit lanes luma, U, luma, V.
// - 32-bit 4:4:4: top bits ignored; fixed 8-bit and 10-bit layouts.
// - 64-bit 4:4:4: U lowest lane, Y 31:16, V 47:32, top lane ignored.
// - Horizontal mirror is applied before rotation.
// - Watermark level with bit 31 clear is disabled.
// - Buffer is two halves of 1024 blocks, 0-1023 and 1024-2047.
`ifndef DISP_DEFINES_SVH
`define DISP_DEFINES_SVH

// ======================================================
// Register byte offsets
`define OFS_PCTL  8'h00
`define OFS_PSURF 8'h04
`define OFS_CCTL  8'h08
`define OFS_CCMP  8'h0c
`define OFS_CSURF 8'h10
`define OFS_BUF   8'h14
`define OFS_WM    8'h18
`define OFS_STAT  8'h1c
`define RST_REG   32'h0000_0000

// ======================================================
// Control fields
`define F_EN      0
`define F_FMT     5:1
`define F_HFLIP   6
`define F_ROT     8:7
`define F_PLANE   11:9
`define F_BSTART  10:0
`define F_BEND    26:16
`define F_WM_EN   31

// ======================================================
// Status bits
`define S_PARM    0
`define S_CARM    1
`define S_REF     2
`define S_WM      3

// ======================================================
// Constants
`define HALF_TWO  11'h400
`define HDR_LO    3'h1
`define HDR_HI    3'h3
`define SDR_MASK  16'hffc0
`define RESP_OKAY 1'b0

`endif

/* disp_pkg.sv */
package disp_pkg;

  typedef enum logic [4:0] {
    bgra8, rgba8, bgra10, rgba10,
    fp16_bgra, fp16_rgba, uint_bgra, uint_rgba,
    extended_range_bias, bgr565,
    yuv420_8bit_two_plane, yuv420_10bit_two_plane,
    yuv420_12bit_two_plane, yuv420_16bit_two_plane,
    yuv422_yuyv8, yuv422_uyvy8, yuv422_yvyu8, yuv422_vyuy8,
    yuv422_10bit_packed, yuv422_12bit_packed, yuv422_16bit_packed,
    yuv444_8bit, yuv444_10bit_packed, yuv444_12bit_packed,
    yuv444_16bit_packed
  } fmt_e;

  // MSB-aligned components; YUV puts V in r, Y in g, U in b, second Y in a
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] r;
    logic [15:0] g;
    logic [15:0] b;
  } pix_s;

  typedef struct packed {
    logic xrev;
    logic yrev;
    logic swap;
  } orient_s;

endpackage : disp_pkg

/* display_plane_pixel_unpack.sv */
`timescale 1ns/1ps
`include "disp_defines.svh"

module display_plane_pixel_unpack (
  input  wire logic             MCLK_IN,
  input  wire logic             RST_N_IN,
  input  wire logic             CE_IN,
  input  wire logic             HSEL_IN,
  input  wire logic [7:0]       HADDR_IN,
  input  wire logic [1:0]       HTRANS_IN,
  input  wire logic             HWRITE_IN,
  input  wire logic [2:0]       HSIZE_IN,
  input  wire logic [31:0]      HWDATA_IN,
  input  wire logic             HREADY_IN,
  output logic      [31:0]      HRDATA_OUT,
  output logic                  HREADYOUT_OUT,
  output logic                  HRESP_OUT,
  input  wire logic             VBLANK_IN,
  input  wire logic             PIPE_EN_IN,
  input  wire logic             PIPE_HDR_IN,
  input  wire logic             PIX_VALID_IN,
  input  wire logic [63:0]      PIX_DATA_IN,
  input  wire logic [31:0]      PIX_CHROMA_IN,
  output disp_pkg::pix_s        PIX_OUT,
  output logic                  PIX_VALID_OUT,
  output logic                  PIX_REJECT_OUT,
  output logic                  PIX_HIPREC_OUT,
  output logic                  PIX_BYPASS_OUT,
  output disp_pkg::orient_s     ORIENT_OUT,
  output logic      [31:0]      PLANE_BASE_OUT,
  output logic      [31:0]      CURSOR_CONTROL_REG_OUT,
  output logic      [31:0]      CUR_COMP_OUT,
  output logic      [31:0]      CURSOR_SURFACE_BASE_OUT,
  output logic                  WM0_EN_OUT,
  output logic      [1:0]       BUF_HALF_OUT
);
  import disp_pkg::*;

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // ======================================================
  // Functions
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction : hit

  function automatic logic is64(input fmt_e f);
    return f inside {fp16_bgra, fp16_rgba, uint_bgra, uint_rgba};
  endfunction : is64

  function automatic orient_s orient(input logic h,
                                     input logic [1:0] r);
    orient_s o;
    o.swap = r[0];
    // Mirror acts on source x, which lands on y once axes swap
    o.xrev = r[1] ^ (h & ~r[0]);
    o.yrev = (r[1] ^ r[0]) ^ (h & r[0]);
    return o;
  endfunction : orient

  function automatic pix_s unpack(input fmt_e f,
                                  input logic [63:0] d,
                                  input logic [31:0] c);
    pix_s p;
    p = '0;
    case (f)
      bgra8: p = {d[31:24], 8'h00, d[23:16], 8'h00,
                  d[15:8], 8'h00, d[7:0], 8'h00};
      rgba8: p = {d[31:24], 8'h00, d[7:0], 8'h00,
                  d[15:8], 8'h00, d[23:16], 8'h00};
      bgra10: p = {d[31:30], 14'h0000, d[29:20], 6'h00,
                   d[19:10], 6'h00, d[9:0], 6'h00};
      rgba10,
      extended_range_bias: p = {d[31:30], 14'h0000, d[9:0], 6'h00,
                                d[19:10], 6'h00, d[29:20], 6'h00};
      fp16_bgra: p = d;
      fp16_rgba: p = {d[63:48], d[15:0], d[31:16], d[47:32]};
      uint_bgra: p = {d[63:56], 8'h00, d[47:0]};
      uint_rgba: p = {d[63:56], 8'h00, d[15:0], d[31:16], d[47:32]};
      bgr565: p = {16'h0000, d[15:11], 11'h000, d[10:5], 10'h000,
                   d[4:0], 11'h000};
      yuv420_8bit_two_plane: p = {16'h0000, c[7:0], 8'h00,
                                  d[7:0], 8'h00, c[15:8], 8'h00};
      yuv420_10bit_two_plane: p = {16'h0000, c[15:6], 6'h00,
                                   d[15:6], 6'h00, c[31:22], 6'h00};
      yuv420_12bit_two_plane: p = {16'h0000, c[15:4], 4'h0,
                                   d[15:4], 4'h0, c[31:20], 4'h0};
      yuv420_16bit_two_plane: p = {16'h0000, c[15:0], d[15:0], c[31:16]};
      yuv422_yuyv8: p = {d[23:16], 8'h00, d[31:24], 8'h00,
                         d[7:0], 8'h00, d[15:8], 8'h00};
      yuv422_uyvy8: p = {d[31:24], 8'h00, d[23:16], 8'h00,
                         d[15:8], 8'h00, d[7:0], 8'h00};
      yuv422_yvyu8: p = {d[23:16], 8'h00, d[15:8], 8'h00,
                         d[7:0], 8'h00, d[31:24], 8'h00};
      yuv422_vyuy8: p = {d[31:24], 8'h00, d[7:0], 8'h00,
                         d[15:8], 8'h00, d[23:16], 8'h00};
      yuv422_10bit_packed: p = {d[47:38], 6'h00, d[63:54], 6'h00,
                                d[15:6], 6'h00, d[31:22], 6'h00};
      yuv422_12bit_packed: p = {d[47:36], 4'h0, d[63:52], 4'h0,
                                d[15:4], 4'h0, d[31:20], 4'h0};
      yuv422_16bit_packed: p = {d[47:32], d[63:48], d[15:0], d[31:16]};
      yuv444_8bit: p = {16'h0000, d[7:0], 8'h00, d[23:16], 8'h00,
                        d[15:8], 8'h00};
      yuv444_10bit_packed: p = {16'h0000, d[29:20], 6'h00,
                                d[19:10], 6'h00, d[9:0], 6'h00};
      yuv444_12bit_packed: p = {16'h0000, d[47:36], 4'h0,
                                d[31:20], 4'h0, d[15:4], 4'h0};
      yuv444_16bit_packed: p = {16'h0000, d[47:32], d[31:16], d[15:0]};
      default: p = '0;
    endcase
    return p;
  endfunction : unpack

  // ======================================================
  // AHB-Lite slave
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  ad_q;
  logic [31:0] rdata;
  logic        take;

  assign take = HSEL_IN & HREADY_IN & HTRANS_IN[1];

  // Reads take one wait state so a write in the previous data phase is seen
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      wr_q          <= 1'b0;
      rd_q          <= 1'b0;
      ad_q          <= 8'h00;
      HREADYOUT_OUT <= 1'b1;
      HRDATA_OUT    <= `RST_REG;
      HRESP_OUT     <= `RESP_OKAY;
    end else if (CE_IN) begin
      wr_q          <= take & HWRITE_IN;
      rd_q          <= take & ~HWRITE_IN;
      HREADYOUT_OUT <= ~(take & ~HWRITE_IN);
      HRESP_OUT     <= `RESP_OKAY;
      if (take) begin
        ad_q <= HADDR_IN;
      end
      if (rd_q) begin
        HRDATA_OUT <= rdata;
      end
    end
  end

  // ======================================================
  // Registers
  logic [31:0] pctl_q;
  logic [31:0] pact_q;
  logic [31:0] psurf_q;
  logic [31:0] cctl_q;
  logic [31:0] ccmp_q;
  logic [31:0] csurf_q;
  logic [31:0] buf_q;
  logic [31:0] wm_q;
  logic        parm_q;
  logic        carm_q;
  logic        upd_p;
  logic        upd_c;
  logic        refused;

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      pctl_q  <= `RST_REG;
      psurf_q <= `RST_REG;
      cctl_q  <= `RST_REG;
      ccmp_q  <= `RST_REG;
      csurf_q <= `RST_REG;
      buf_q   <= `RST_REG;
      wm_q    <= `RST_REG;
    end else if (CE_IN && wr_q) begin
      if (hit(ad_q, `OFS_PCTL)) begin
        pctl_q <= HWDATA_IN;
      end else if (hit(ad_q, `OFS_PSURF)) begin
        psurf_q <= HWDATA_IN;
      end else if (hit(ad_q, `OFS_CCTL)) begin
        cctl_q <= HWDATA_IN;
      end else if (hit(ad_q, `OFS_CCMP)) begin
        ccmp_q <= HWDATA_IN;
      end else if (hit(ad_q, `OFS_CSURF)) begin
        csurf_q <= HWDATA_IN;
      end else if (hit(ad_q, `OFS_BUF)) begin
        buf_q <= HWDATA_IN;
      end else if (hit(ad_q, `OFS_WM)) begin
        wm_q <= HWDATA_IN;
      end
    end
  end

  always_comb begin
    rdata = `RST_REG;
    if (hit(ad_q, `OFS_PCTL)) begin
      rdata = pctl_q;
    end else if (hit(ad_q, `OFS_PSURF)) begin
      rdata = psurf_q;
    end else if (hit(ad_q, `OFS_CCTL)) begin
      rdata = cctl_q;
    end else if (hit(ad_q, `OFS_CCMP)) begin
      rdata = ccmp_q;
    end else if (hit(ad_q, `OFS_CSURF)) begin
      rdata = csurf_q;
    end else if (hit(ad_q, `OFS_BUF)) begin
      rdata = buf_q;
    end else if (hit(ad_q, `OFS_WM)) begin
      rdata = wm_q;
    end else if (hit(ad_q, `OFS_STAT)) begin
      rdata[`S_PARM] = parm_q;
      rdata[`S_CARM] = carm_q;
      rdata[`S_REF]  = refused;
      rdata[`S_WM]   = WM0_EN_OUT;
    end
  end

  // ======================================================
  // Double-buffered plane and cursor controls
  assign upd_p = parm_q & (VBLANK_IN | ~PIPE_EN_IN | ~pact_q[`F_EN]);
  assign upd_c = carm_q & (VBLANK_IN | ~PIPE_EN_IN | ~CURSOR_CONTROL_REG_OUT[`F_EN]);

  // A base write in the update cycle re-arms: the set wins over the clear
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      parm_q         <= 1'b0;
      pact_q         <= `RST_REG;
      PLANE_BASE_OUT <= `RST_REG;
    end else if (CE_IN) begin
      if (wr_q && hit(ad_q, `OFS_PSURF)) begin
        parm_q <= 1'b1;
      end else if (upd_p) begin
        parm_q <= 1'b0;
      end
      if (upd_p) begin
        pact_q         <= pctl_q;
        PLANE_BASE_OUT <= psurf_q;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      carm_q       <= 1'b0;
      CURSOR_CONTROL_REG_OUT  <= `RST_REG;
      CUR_COMP_OUT <= `RST_REG;
      CURSOR_SURFACE_BASE_OUT <= `RST_REG;
    end else if (CE_IN) begin
      if (wr_q && hit(ad_q, `OFS_CSURF)) begin
        carm_q <= 1'b1;
      end else if (upd_c) begin
        carm_q <= 1'b0;
      end
      if (upd_c) begin
        CURSOR_CONTROL_REG_OUT  <= cctl_q;
        CUR_COMP_OUT <= ccmp_q;
        CURSOR_SURFACE_BASE_OUT <= csurf_q;
      end
    end
  end

  // ======================================================
  // Buffer range and watermark
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      WM0_EN_OUT   <= 1'b0;
      BUF_HALF_OUT <= 2'h0;
    end else if (CE_IN) begin
      WM0_EN_OUT      <= wm_q[`F_WM_EN];
      BUF_HALF_OUT[0] <= buf_q[`F_BSTART] < `HALF_TWO;
      BUF_HALF_OUT[1] <= buf_q[`F_BEND] >= `HALF_TWO;
    end
  end

  // ======================================================
  // Pixel path
  fmt_e       fmt;
  logic [2:0] plane;
  logic       hdr_plane;
  logic       hiprec;
  pix_s       px;

  assign fmt       = fmt_e'(pact_q[`F_FMT]);
  assign plane     = pact_q[`F_PLANE];
  assign hdr_plane = (plane >= `HDR_LO) && (plane <= `HDR_HI);
  assign refused   = is64(fmt) & ~hdr_plane;
  assign hiprec    = hdr_plane & PIPE_HDR_IN;
  assign px        = unpack(fmt, PIX_DATA_IN, PIX_CHROMA_IN);

  // Reduced precision keeps the top ten bits of every component
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      PIX_OUT        <= '0;
      PIX_VALID_OUT  <= 1'b0;
      PIX_REJECT_OUT <= 1'b0;
      PIX_HIPREC_OUT <= 1'b0;
      PIX_BYPASS_OUT <= 1'b0;
      ORIENT_OUT     <= '0;
    end else if (CE_IN) begin
      PIX_VALID_OUT  <= PIX_VALID_IN & pact_q[`F_EN] & ~refused;
      PIX_REJECT_OUT <= PIX_VALID_IN & pact_q[`F_EN] & refused;
      PIX_HIPREC_OUT <= hiprec;
      PIX_BYPASS_OUT <= PIPE_HDR_IN & ~hdr_plane;
      ORIENT_OUT     <= orient(pact_q[`F_HFLIP], pact_q[`F_ROT]);
      if (PIX_VALID_IN) begin
        PIX_OUT <= hiprec ? px : pix_s'(px & {4{`SDR_MASK}});
      end
    end
  end

  // ======================================================
  // Checks
  property p_cur_upd;
    CE_IN && carm_q && (VBLANK_IN || !PIPE_EN_IN)
      |=> CURSOR_CONTROL_REG_OUT == $past(cctl_q) && CUR_COMP_OUT == $past(ccmp_q);
  endproperty
  a_cur_upd: assert property (p_cur_upd) else $error("cursor not latched");

  property p_cur_hold;
    CE_IN && !carm_q |=> $stable(CURSOR_CONTROL_REG_OUT) && $stable(CUR_COMP_OUT);
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("cursor changed unarmed");

  property p_pl_upd;
    CE_IN && parm_q && !PIPE_EN_IN |=> PLANE_BASE_OUT == $past(psurf_q);
  endproperty
  a_pl_upd: assert property (p_pl_upd) else $error("plane not latched");

  property p_pl_wait;
    CE_IN && parm_q && !VBLANK_IN && PIPE_EN_IN && pact_q[`F_EN]
      |=> $stable(PLANE_BASE_OUT) && parm_q;
  endproperty
  a_pl_wait: assert property (p_pl_wait) else $error("plane latched early");

  property p_bgra8;
    CE_IN && PIX_VALID_IN && fmt == bgra8
      |=> PIX_OUT.r[15:8] == $past(PIX_DATA_IN[23:16])
          && PIX_OUT.b[15:8] == $past(PIX_DATA_IN[7:0]);
  endproperty
  a_bgra8: assert property (p_bgra8) else $error("bgra8 unpack wrong");

  property p_refuse;
    CE_IN && PIX_VALID_IN && pact_q[`F_EN] && is64(fmt) && plane == 3'h0
      |=> PIX_REJECT_OUT && !PIX_VALID_OUT;
  endproperty
  a_refuse: assert property (p_refuse) else $error("64-bit on sdr plane");

  property p_hiprec;
    CE_IN && PIX_VALID_IN && !PIPE_HDR_IN |=> !PIX_HIPREC_OUT && PIX_OUT.g[5:0] == 6'h00;
  endproperty
  a_hiprec: assert property (p_hiprec) else $error("precision not reduced");

  property p_nv;
    CE_IN && PIX_VALID_IN && fmt == yuv420_8bit_two_plane
      |=> PIX_OUT.g[15:8] == $past(PIX_DATA_IN[7:0])
          && PIX_OUT.b[15:8] == $past(PIX_CHROMA_IN[15:8]);
  endproperty
  a_nv: assert property (p_nv) else $error("4:2:0 unpack wrong");

  property p_flip;
    CE_IN && pact_q[`F_HFLIP] && pact_q[`F_ROT] == 2'h1
      |=> ORIENT_OUT.swap && !ORIENT_OUT.yrev && !ORIENT_OUT.xrev;
  endproperty
  a_flip: assert property (p_flip) else $error("mirror order wrong");

  property p_wm;
    CE_IN |=> WM0_EN_OUT == $past(wm_q[`F_WM_EN]);
  endproperty
  a_wm: assert property (p_wm) else $error("watermark enable wrong");

endmodule : display_plane_pixel_unpack

/* display_plane_pixel_unpack_tb.sv */
`timescale 1ns/1ps
`include "disp_defines.svh"
module display_plane_pixel_unpack_tb;
  import disp_pkg::*;
  localparam logic [63:0] PD = 64'h1122_3344_a5c3_96f0;
  localparam logic [31:0] PC = 32'h6b2d_e817;
  logic        mclk, rst_n, ce, hsel, hwrite, vblank, pipe_en, pipe_hdr;
  logic        hreadyout, hresp, pv, rej, hiprec, bypass, wm0, vin;
  logic [7:0]  haddr;
  logic [1:0]  htrans, bhalf;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q, cin, pbase, cctl, ccmp, cbase;
  logic [63:0] din;
  pix_s        pix;
  orient_s     ori;
  int          fails, tests_run;
  logic [63:0] pexp [25] = '{
    64'ha500_c300_9600_f000, 64'ha500_f000_9600_c300, 64'h8000_9700_3940_bc00,
    64'h8000_bc00_3940_9700, 64'h1122_3344_a5c3_96f0, 64'h1122_96f0_a5c3_3344,
    64'h1100_3344_a5c3_96f0, 64'h1100_96f0_a5c3_3344, 64'h8000_bc00_3940_9700,
    64'h0000_9000_dc00_8000, 64'h0000_1700_f000_e800, 64'h0000_e800_96c0_6b00,
    64'h0000_e810_96f0_6b20, 64'h0000_e817_96f0_6b2d, 64'hc300_a500_f000_9600,
    64'ha500_c300_9600_f000, 64'hc300_9600_f000_a500, 64'ha500_f000_9600_c300,
    64'h3340_1100_96c0_a5c0, 64'h3340_1120_96f0_a5c0, 64'h3344_1122_96f0_a5c3,
    64'h0000_f000_c300_9600, 64'h0000_9700_3940_bc00, 64'h0000_3340_a5c0_96f0,
    64'h0000_3344_a5c3_96f0};
  logic [2:0]  otab [8] = '{3'h0, 3'h3, 3'h6, 3'h5, 3'h4, 3'h1, 3'h2, 3'h7};
  // Last range: one pipe, 8 cursor blocks held back from 2048, ends at 2039
  logic [31:0] btab [6] = '{32'h009f_0000, 32'h013f_00a0, 32'h01df_0140,
                            32'h07ff_0400, 32'h0400_03ff, 32'h07f7_0000};
  logic [1:0]  htab [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};

  display_plane_pixel_unpack u_display_plane_pixel_unpack (
    .MCLK_IN(mclk), .RST_N_IN(rst_n), .CE_IN(ce), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata), .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .VBLANK_IN(vblank),
    .PIPE_EN_IN(pipe_en), .PIPE_HDR_IN(pipe_hdr), .PIX_VALID_IN(vin),
    .PIX_DATA_IN(din), .PIX_CHROMA_IN(cin), .PIX_OUT(pix), .PIX_VALID_OUT(pv),
    .PIX_REJECT_OUT(rej), .PIX_HIPREC_OUT(hiprec), .PIX_BYPASS_OUT(bypass),
    .ORIENT_OUT(ori), .PLANE_BASE_OUT(pbase), .CURSOR_CONTROL_REG_OUT(cctl),
    .CUR_COMP_OUT(ccmp), .CURSOR_SURFACE_BASE_OUT(cbase), .WM0_EN_OUT(wm0),
    .BUF_HALF_OUT(bhalf));

  pix_fetch_model u_pix_fetch_model (
    .clk_in(mclk), .pix_in(pix), .valid_in(pv), .reject_in(rej),
    .valid_out(vin), .data_out(din), .chroma_out(cin));

  // ==========
  // Checking and bus tasks
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // No local limit: only the watchdog ends a stuck wait
  task automatic wait_rdy;
    do begin
      @(posedge mclk);
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : ahb

  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task automatic pulse;
    @(posedge mclk);
    vblank <= 1'b1;
    @(posedge mclk);
    vblank <= 1'b0;
    settle();
  endtask : pulse

  function automatic logic [31:0] mk(input logic [4:0] f, input logic [2:0] pl,
                                     input logic [2:0] o);
    mk = {20'h0, pl, o[1:0], o[2], f, 1'b1};
  endfunction : mk

  task automatic cfg(input logic [31:0] c, input logic [31:0] b);
    ahb(1'b1, `OFS_PCTL, c);
    ahb(1'b1, `OFS_PSURF, b);
    settle();
  endtask : cfg

  task automatic px(input logic [31:0] c, input logic [3:0] fl, input logic [63:0] p);
    cfg(c, 32'h0);
    u_pix_fetch_model.send(PD, PC);
    #1;
    chk({pv, rej, hiprec, bypass}, fl);
    if (fl[3]) chk(pix, p);
  endtask : px

  task automatic cur(input logic [31:0] c, input logic [31:0] m, input logic [31:0] b);
    ahb(1'b1, `OFS_CCTL, c);
    ahb(1'b1, `OFS_CCMP, m);
    ahb(1'b1, `OFS_CSURF, b);
    settle();
  endtask : cur

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Whole run is near 600 cycles; the 20000-cycle limit means a hang
  initial begin
    #80000;
    fails++;
    print_verdict();
  end

  // ==========
  // Main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    hwrite = 1'b0;
    haddr = 8'h0;
    htrans = 2'h0;
    hwdata = 32'h0;
    vblank = 1'b0;
    pipe_en = 1'b0;
    pipe_hdr = 1'b1;
    repeat (15) @(posedge mclk);
    #1;
    chk({hreadyout, hresp, pv, rej, wm0}, 5'h10);
    @(posedge mclk);
    rst_n <= 1'b1;
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    ahb(1'b1, `OFS_STAT, 32'hffff_ffff);
    ahb(1'b0, `OFS_STAT, 32'h0);
    chk(q, 32'h0);
    for (int f = 0; f < 25; f++) begin
      px(mk(f[4:0], 3'h1, 3'h0), 4'b1010, pexp[f]);
    end
    px(mk(5'd4, 3'h0, 3'h0), 4'b0101, 64'h0);
    px(mk(5'd7, 3'h7, 3'h0), 4'b0101, 64'h0);
    ahb(1'b0, `OFS_STAT, 32'h0);
    chk(q[`S_REF], 1'b1);
    px(mk(5'd13, 3'h0, 3'h0), 4'b1001, 64'h0000_e800_96c0_6b00);
    @(posedge mclk);
    pipe_hdr <= 1'b0;
    px(mk(5'd13, 3'h1, 3'h0), 4'b1000, 64'h0000_e800_96c0_6b00);
    for (int i = 0; i < 8; i++) begin
      cfg(mk(5'd0, 3'h1, i[2:0]), 32'h0);
      chk(ori, otab[i]);
    end
    px(mk(5'd0, 3'h0, 3'h0) & 32'hffff_fffe, 4'b0000, 64'h0);
    @(posedge mclk);
    pipe_en <= 1'b1;
    cfg(mk(5'd0, 3'h1, 3'h0), 32'h0000_aaa0);
    chk(pbase, 32'h0000_aaa0);
    cfg(mk(5'd1, 3'h1, 3'h0), 32'h0000_bbb0);
    chk(pbase, 32'h0000_aaa0);
    ahb(1'b0, `OFS_STAT, 32'h0);
    chk(q[`S_PARM], 1'b1);
    pulse();
    chk(pbase, 32'h0000_bbb0);
    u_pix_fetch_model.send(PD, PC);
    #1;
    chk(pix, pexp[1]);
    cur(32'h1, 32'h0c0c, 32'hc000);
    chk({cctl, ccmp, cbase}, {32'h1, 32'h0c0c, 32'hc000});
    cur(32'h25, 32'h0d0d, 32'hd000);
    chk({cctl, ccmp, cbase}, {32'h1, 32'h0c0c, 32'hc000});
    ahb(1'b0, `OFS_STAT, 32'h0);
    chk(q[`S_CARM], 1'b1);
    pulse();
    chk({cctl, ccmp, cbase}, {32'h25, 32'h0d0d, 32'hd000});
    cur(32'h27, 32'h0e0e, 32'he000);
    @(posedge mclk);
    pipe_en <= 1'b0;
    settle();
    chk({cctl, ccmp, cbase}, {32'h27, 32'h0e0e, 32'he000});
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, `OFS_BUF, btab[i]);
      pulse();
      chk(bhalf, htab[i]);
    end
    ahb(1'b1, `OFS_WM, 32'h8000_80a0);
    settle();
    chk(wm0, 1'b1);
    ahb(1'b0, `OFS_STAT, 32'h0);
    chk(q[`S_WM], 1'b1);
    ahb(1'b1, `OFS_WM, 32'h0000_80a0);
    settle();
    chk(wm0, 1'b0);
    // Clock enable low must freeze the pixel path entirely
    @(posedge mclk);
    ce <= 1'b0;
    u_pix_fetch_model.send(~PD, PC);
    #1;
    chk({pv, pix}, {1'b0, pexp[1]});
    @(posedge mclk);
    ce <= 1'b1;
    chk(u_pix_fetch_model.last_pix, pexp[1]);
    chk(u_pix_fetch_model.accepted, 28);
    chk(u_pix_fetch_model.refused, 2);
    print_verdict();
  end
endmodule : display_plane_pixel_unpack_tb

/* pix_fetch_model.sv */
`timescale 1ns/1ps
// ==========
// Fetch side feeds pixel words; blend side counts what comes back
module pix_fetch_model (
  input  wire logic           clk_in,
  input  wire disp_pkg::pix_s pix_in,
  input  wire logic           valid_in,
  input  wire logic           reject_in,
  output logic                valid_out,
  output logic [63:0]         data_out,
  output logic [31:0]         chroma_out
);
  import disp_pkg::*;
  int   accepted;
  int   refused;
  pix_s last_pix;

  initial begin
    valid_out = 1'b0;
    data_out = 64'h0;
    chroma_out = 32'h0;
    accepted = 0;
    refused = 0;
  end

  task automatic send(input logic [63:0] d, input logic [31:0] c);
    @(posedge clk_in);
    valid_out <= 1'b1;
    data_out <= d;
    chroma_out <= c;
    @(posedge clk_in);
    valid_out <= 1'b0;
    // Released lines flip so a late sample cannot match by luck
    data_out <= ~d;
    chroma_out <= ~c;
  endtask : send

  always @(posedge clk_in) begin
    if (valid_in) begin
      accepted <= accepted + 1;
      last_pix <= pix_in;
    end
    if (reject_in) begin
      refused <= refused + 1;
    end
  end
endmodule : pix_fetch_model
